// *** logic/pattern_trigger_sync.v ***
// Trigger, sync, role and light-source control for pattern display
// Summary of operation
// (RULE1) Advance trigger steps to next pattern
// (RULE2) Run trigger rising edge starts display
// (RULE3) Run trigger falling edge stops display
// (RULE4) Software start/stop acts alongside run trigger
// (RULE5) Exposure output high only while exposing
// (RULE6) First-pattern output high on first pattern
// (RULE7) Role pin high primary, low secondary
// (RULE8) Secondary drives peer-present high when ready
// (RULE9) Secondary leaves trigger and light pins unused
// (RULE10) Primary uses peer select as chip select
// (RULE11) Separate PWM output per colour
// (RULE12) Separate enable output per colour
// (RULE13) Trigger inputs pass a synchroniser first
`timescale 1ns/100ps
module pattern_trigger_sync
(
  input  wire       mclk,
  input  wire       reset,
  input  wire       video_pattern_mode,
  input  wire       role_select_in,
  input  wire       pattern_advance_in,
  input  wire       pattern_run_in,
  input  wire       sw_start,
  input  wire       sw_stop,
  input  wire [7:0] pattern_count,
  input  wire       exposing,
  input  wire       ready,
  input  wire       peer_present_in,
  input  wire       ssp_select_req,
  input  wire [2:0] light_enable_req,
  input  wire [7:0] blue_duty,
  input  wire [7:0] green_duty,
  input  wire [7:0] red_duty,
  output reg        is_primary_r,
  output reg        running_r,
  output reg  [7:0] pattern_index_r,
  output reg        peer_ready_r,
  output reg        exposure_out,
  output reg        exposure_out_oe,
  output reg        first_pattern_out,
  output reg        first_pattern_out_oe,
  output reg        peer_present_out,
  output reg        peer_present_oe,
  output reg        peer_serial_select_n_out,
  output reg        peer_serial_select_oe,
  output reg        blue_light_pwm,
  output reg        green_light_pwm,
  output reg        red_light_pwm,
  output reg        blue_light_enable,
  output reg        green_light_enable,
  output reg        red_light_enable,
  output reg        light_pins_oe
);
`include "pattern_trigger_sync_regs.vh"

  wire       adv_s;
  wire       run_s;
  wire       role_s;
  wire       peer_s;
  reg        adv_d_r;
  reg        run_d_r;
  reg  [2:0] role_wait_r;
  wire       role_known;
  reg  [7:0] pwm_cnt_r;
  reg  [7:0] idx_nxt;
  reg        run_nxt;
  wire       adv_rise;
  wire       run_rise;
  wire       run_fall;
  wire       trig_ok;
  wire [7:0] last_idx;

  trig_sync3 u_adv (.mclk(mclk), .reset(reset), .din(pattern_advance_in),
                    .dout_r(adv_s));
  trig_sync3 u_run (.mclk(mclk), .reset(reset), .din(pattern_run_in),
                    .dout_r(run_s));
  trig_sync3 u_role (.mclk(mclk), .reset(reset), .din(role_select_in),
                     .dout_r(role_s));
  trig_sync3 u_peer (.mclk(mclk), .reset(reset), .din(peer_present_in),
                     .dout_r(peer_s));

  // Compare duty against free-running count
  function pwm_bit;
    input [7:0] duty;
    input [7:0] cnt;
    begin
      pwm_bit = (cnt < duty);
    end
  endfunction

  // Rising edge of a synchronised level against its delayed copy
  function edge_up;
    input cur;
    input prev;
    begin
      edge_up = cur & ~prev;
    end
  endfunction

  // Wrap to the first pattern after the last one of the sequence
  // A count that shrinks below the index also wraps, never runs away
  function [7:0] step_index;
    input [7:0] idx;
    input [7:0] last;
    begin
      if (idx >= last)
        step_index = `PAT_IDX_FIRST;
      else
        step_index = idx + `PAT_STEP;
    end
  endfunction

  assign adv_rise = edge_up(adv_s, adv_d_r);
  assign run_rise = edge_up(run_s, run_d_r);
  assign run_fall = edge_up(run_d_r, run_s);
  // Strap is only trusted once the synchroniser has filled
  assign role_known = (role_wait_r == `ROLE_WAIT_LAST); // RULE7
  // Triggers only matter for a primary in video pattern mode
  assign trig_ok  = video_pattern_mode & is_primary_r; // RULE9
  assign last_idx = (pattern_count == `PAT_IDX_FIRST) ? `PAT_IDX_FIRST
                    : pattern_count - `PAT_STEP;

  always @*
  begin
    run_nxt = running_r;
    idx_nxt = pattern_index_r;
    // Stop wins if both sources collide in one cycle, the safe choice
    if (sw_start | (trig_ok & run_rise)) // RULE2 RULE4
    begin
      run_nxt = `ST_RUN;
      if (!running_r)
        idx_nxt = `PAT_IDX_FIRST;
    end
    if (sw_stop | (trig_ok & run_fall)) // RULE3 RULE4
      run_nxt = `ST_IDLE;
    if (trig_ok & running_r & adv_rise & run_nxt) // RULE1
      idx_nxt = step_index(pattern_index_r, last_idx); // RULE1
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      adv_d_r         <= 1'b0;
      run_d_r         <= 1'b0;
      role_wait_r     <= `ROLE_WAIT_RST;
      is_primary_r    <= 1'b0;
      running_r       <= `ST_IDLE;
      pattern_index_r <= `PAT_IDX_FIRST;
      peer_ready_r    <= 1'b0;
      pwm_cnt_r       <= `PWM_CNT_RST;
    end
    else
    begin
      adv_d_r <= adv_s;
      run_d_r <= run_s;
      // Raw strap is never read: a metastable role would glitch pins
      if (!role_known)
        role_wait_r <= role_wait_r + `ROLE_WAIT_STEP;
      is_primary_r <= role_s; // RULE7
      running_r       <= run_nxt;
      pattern_index_r <= idx_nxt;
      peer_ready_r    <= is_primary_r & peer_s; // RULE8
      pwm_cnt_r <= (pwm_cnt_r >= `PWM_CNT_LAST) ? `PWM_CNT_RST
                   : pwm_cnt_r + `PWM_STEP;
    end
  end

  // Registered pin outputs; secondary drives only the presence pin
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      exposure_out             <= 1'b0;
      exposure_out_oe          <= 1'b0;
      first_pattern_out        <= 1'b0;
      first_pattern_out_oe     <= 1'b0;
      peer_present_out         <= 1'b0;
      peer_present_oe          <= 1'b0;
      peer_serial_select_n_out <= 1'b1;
      peer_serial_select_oe    <= 1'b0;
      blue_light_pwm           <= 1'b0;
      green_light_pwm          <= 1'b0;
      red_light_pwm            <= 1'b0;
      blue_light_enable        <= 1'b0;
      green_light_enable       <= 1'b0;
      red_light_enable         <= 1'b0;
      light_pins_oe            <= 1'b0;
    end
    else
    begin
      exposure_out      <= is_primary_r & running_r & exposing; // RULE5
      first_pattern_out <= is_primary_r & running_r & exposing
                           & (pattern_index_r == `PAT_IDX_FIRST); // RULE6
      // Output enables stay low until the strap has been read, so a
      // primary never drives the presence wire just after reset
      exposure_out_oe      <= role_known & is_primary_r; // RULE9
      first_pattern_out_oe <= role_known & is_primary_r; // RULE9
      light_pins_oe        <= role_known & is_primary_r; // RULE9
      peer_present_out <= ~is_primary_r & ready; // RULE8
      peer_present_oe  <= role_known & ~is_primary_r; // RULE8
      peer_serial_select_n_out <= ~(is_primary_r & ssp_select_req); // RULE10
      peer_serial_select_oe    <= role_known & is_primary_r; // RULE10
      blue_light_pwm  <= is_primary_r
                         & pwm_bit(blue_duty, pwm_cnt_r); // RULE11
      green_light_pwm <= is_primary_r
                         & pwm_bit(green_duty, pwm_cnt_r); // RULE11
      red_light_pwm   <= is_primary_r
                         & pwm_bit(red_duty, pwm_cnt_r); // RULE11
      blue_light_enable  <= is_primary_r & light_enable_req[0]; // RULE12
      green_light_enable <= is_primary_r & light_enable_req[1]; // RULE12
      red_light_enable   <= is_primary_r & light_enable_req[2]; // RULE12
    end
  end
endmodule // pattern_trigger_sync

// *** logic/pattern_trigger_sync_regs.vh ***
// Constants for the pattern trigger and synchronisation block
`ifndef PATTERN_TRIGGER_SYNC_REGS_VH
`define PATTERN_TRIGGER_SYNC_REGS_VH
`define PAT_IDX_W        8
`define PAT_IDX_FIRST    8'h00
`define PAT_COUNT_RST    8'h08
`define PWM_W            8
`define PWM_DUTY_RST     8'h00
`define PWM_CNT_RST      8'h00
`define PWM_CNT_LAST     8'hFE
`define SYNC_RST         3'h0
`define ST_IDLE          1'h0
`define ST_RUN           1'h1
`define PAT_STEP         8'h01
`define PWM_STEP         8'h01
`define ROLE_WAIT_RST    3'h0
`define ROLE_WAIT_STEP   3'h1
`define ROLE_WAIT_LAST   3'h5
`endif

// *** logic/trig_sync3.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module trig_sync3
(
  input  wire mclk,
  input  wire reset,
  input  wire din,
  output reg  dout_r
);
`include "pattern_trigger_sync_regs.vh"
  reg [2:0] sync_r;
  // Stage 0 feeds only stage 1; output moves once stages 1 and 2 agree
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sync_r <= `SYNC_RST;
      dout_r <= 1'b0;
    end
    else
    begin
      sync_r <= {sync_r[1:0], din}; // RULE13
      if (sync_r[1] == sync_r[2])
        dout_r <= sync_r[2]; // RULE13
    end
  end
endmodule // trig_sync3

// *** bench/peer_model.sv ***
// Peer controller model on the presence wire
`timescale 1ns/100ps
module peer_model
(
  input  wire peer_up,
  input  wire driving,
  output wire level
);
  // Released wire falls to the pull-down level, not the last value
  assign level = driving & peer_up;
endmodule // peer_model

// *** bench/pts_props.sv ***
// Assertion checker for the pattern trigger block
`timescale 1ns/100ps
module pts_props
(
  input wire       mclk,
  input wire       reset,
  input wire       sw_start,
  input wire       sw_stop,
  input wire       exposing,
  input wire       ready,
  input wire       ssp_select_req,
  input wire [2:0] light_enable_req,
  input wire [7:0] blue_duty,
  input wire       is_primary_r,
  input wire       running_r,
  input wire [7:0] pattern_index_r,
  input wire       exposure_out,
  input wire       first_pattern_out,
  input wire       peer_present_out,
  input wire       peer_serial_select_n_out,
  input wire       blue_light_enable,
  input wire       blue_light_pwm,
  input wire       light_pins_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Three cycles let the output enables catch up with a role change
  AST_SEC_OFF: assert property (
    (!is_primary_r)[*3] |-> !light_pins_oe)
    else $error("light pins driven in secondary role");
  AST_FIRST: assert property (first_pattern_out |-> exposure_out)
    else $error("first pattern flagged outside exposure");
  AST_EXPO: assert property (exposure_out |-> $past(exposing))
    else $error("exposure high without exposing");
  AST_PRES: assert property (peer_present_out |-> $past(ready))
    else $error("presence high while not ready");
  AST_CS: assert property (
    !peer_serial_select_n_out |-> $past(ssp_select_req))
    else $error("peer select low without request");
  AST_EN: assert property (blue_light_enable |-> $past(light_enable_req[0]))
    else $error("blue enable without request");
  AST_PWM0: assert property ($past(blue_duty) == 8'h00 |-> !blue_light_pwm)
    else $error("blue pwm high at zero duty");
  AST_STOP: assert property ($past(sw_stop) |-> !running_r)
    else $error("display runs after stop");
  AST_START: assert property ($past(sw_start && !sw_stop && !running_r
    && is_primary_r) |-> running_r && pattern_index_r == 8'h00)
    else $error("start did not begin at first pattern");
  cover property (sw_start && !running_r);
  cover property (exposure_out);
  cover property (!is_primary_r && peer_present_out);
endmodule // pts_props
bind pattern_trigger_sync pts_props u_pts_props (.*);

// *** bench/tb_top.sv ***
// Self-checking bench for the pattern trigger block
`timescale 1ns/100ps
module tb_top;
  logic       mclk, reset, video_pattern_mode, role_select_in, sw_start;
  logic       pattern_advance_in, pattern_run_in, sw_stop, exposing, ready;
  logic       ssp_select_req, peer_up;
  logic [2:0] light_enable_req;
  logic [7:0] pattern_count, blue_duty, green_duty, red_duty;
  wire        peer_present_in, peer_lvl, is_primary_r, running_r, peer_ready_r;
  wire  [7:0] pattern_index_r;
  wire        exposure_out, exposure_out_oe, first_pattern_out;
  wire        first_pattern_out_oe, peer_present_out, peer_present_oe;
  wire        peer_serial_select_n_out, peer_serial_select_oe, light_pins_oe;
  wire        blue_light_pwm, green_light_pwm, red_light_pwm;
  wire        blue_light_enable, green_light_enable, red_light_enable;
  int         n_fail = 0;
  int         checks_done = 0;
  int         g_cnt = 0;
  // Row: run pin, advance pin, running, index
  logic [4:0] rows [9] = '{5'h00, 5'h14, 5'h1D, 5'h15, 5'h1E, 5'h16,
                           5'h1C, 5'h00, 5'h08};
  pattern_trigger_sync u_pattern_trigger_sync (.*);
  peer_model u_peer_model (.peer_up(peer_up), .driving(!peer_present_oe),
                           .level(peer_lvl));
  assign peer_present_in = peer_present_oe ? peer_present_out : peer_lvl;
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    {reset, role_select_in, video_pattern_mode} = 3'h7;
    {pattern_advance_in, pattern_run_in, sw_start, sw_stop} = 4'h0;
    {exposing, ready, peer_up, ssp_select_req} = 4'hE;
    light_enable_req = 3'h5;
    pattern_count = 8'h03;
    blue_duty = 8'h00;
    green_duty = 8'h80;
    red_duty = 8'hFF;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    // Pins pass a synchroniser, so each row waits well past its latency
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk) {pattern_run_in, pattern_advance_in} <= rows[i][4:3];
      repeat (10) @(posedge mclk);
      #1 chk(running_r, rows[i][2]);
      chk(pattern_index_r, {6'h00, rows[i][1:0]});
      chk(exposure_out, rows[i][2]);
      chk(first_pattern_out, rows[i][2] && rows[i][1:0] == 2'h0);
    end
    @(posedge mclk) pattern_advance_in <= 1'b0;
    @(posedge mclk) sw_start <= 1'b1;
    @(posedge mclk) sw_start <= 1'b0;
    #1 chk(running_r, 8'h01);
    @(posedge mclk) {sw_start, sw_stop} <= 2'h3;
    @(posedge mclk) {sw_start, sw_stop} <= 2'h0;
    #1 chk(running_r, 8'h00);
    @(posedge mclk) ssp_select_req <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk({blue_light_enable, green_light_enable, red_light_enable}, 8'h05);
    chk({blue_light_pwm, red_light_pwm}, 8'h01);
    chk(peer_serial_select_n_out, 8'h00);
    chk(peer_ready_r, 8'h01);
    @(posedge mclk) role_select_in <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk(is_primary_r, 8'h00);
    chk({light_pins_oe, exposure_out_oe, red_light_pwm}, 8'h00);
    chk({peer_present_oe, peer_present_out}, 8'h03);
    @(posedge mclk) role_select_in <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(first_pattern_out_oe, 8'h01);
    chk(peer_serial_select_oe, 8'h01);
    // Run pin is ignored outside video pattern mode
    @(posedge mclk) video_pattern_mode <= 1'b0;
    @(posedge mclk) pattern_run_in <= 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(running_r, 8'h00);
    @(posedge mclk) {video_pattern_mode, pattern_run_in} <= 2'h2;
    repeat (8) @(posedge mclk);
    // One full PWM period holds exactly duty high cycles
    repeat (255)
    begin
      @(posedge mclk);
      #1 g_cnt = g_cnt + green_light_pwm;
    end
    chk(g_cnt[7:0], 8'h80);
    // Reset in mid-run, then no false start or role glitch after it
    @(posedge mclk) sw_start <= 1'b1;
    @(posedge mclk) sw_start <= 1'b0;
    @(posedge mclk) reset <= 1'b1;
    #1 chk({running_r, exposure_out, peer_serial_select_n_out}, 8'h01);
    repeat (7) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({peer_present_oe, exposure_out_oe}, 8'h00);
    repeat (8) @(posedge mclk);
    #1 chk(is_primary_r, 8'h01);
    chk(exposure_out_oe, 8'h01);
    chk(running_r, 8'h00);
    finish_test;
  end
endmodule // tb_top
